// file: logic/dps_pkg.sv
// dps_pkg: constants shared by the dpll switchover/phase control core.
// assumes a 10 MHz system clock and byte-wide register writes.
package dps_pkg;
  // clock
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  // register offsets
  localparam logic [11:0] ADDR_SLEW_LO    = 12'h316;
  localparam logic [11:0] ADDR_SLEW_HI    = 12'h317;
  localparam logic [11:0] ADDR_THRESH     = 12'h507;
  localparam logic [11:0] ADDR_STATUS     = 12'h508;
  // reset values
  localparam logic [15:0] SLEW_RESET      = 16'h0000;
  localparam logic [7:0]  THRESH_RESET    = 8'h00;
  // field positions
  localparam int unsigned THRESH_LSB      = 0;
  localparam int unsigned THRESH_W        = 3;
  localparam int unsigned ST_MASTER_BIT   = 0;
  localparam int unsigned ST_PEND_BIT     = 1;
  localparam int unsigned ST_SLEW_BIT     = 2;
  // widths
  localparam int unsigned REF_DIV_W       = 30;
  localparam int unsigned FB_INT_W        = 20;
  localparam int unsigned FRAC_W          = 10;
  localparam int unsigned PRIO_W          = 3;
  localparam int unsigned ACC_W           = 32;
  localparam int unsigned ERR_W           = 32;
  // priority limits
  localparam logic [2:0]  PRIO_HIGHEST    = 3'h0;
  localparam logic [2:0]  PRIO_LOWEST     = 3'h7;
  // slew limit: ns/s scaled to timestamp cycles per sample
  localparam int unsigned SLEW_SHIFT      = 6;
  // loop filter gains (power-of-two shifts)
  localparam int unsigned LF_KP_SHIFT     = 4;
  localparam int unsigned LF_KI_SHIFT     = 8;
  // nominal dds tuning word
  localparam logic [31:0] NOM_FTW         = 32'h0100_0000;
  // counts after reset
  localparam logic [31:0] CNT_RESET       = 32'h0000_0000;
endpackage

// file: logic/dps_loop_filter.sv
// dps_loop_filter: proportional-integral loop filter feeding the dds ftw.
// assumes one phase error word per err_valid pulse on the same clock.
`timescale 1ns/1ps
module dps_loop_filter
  import dps_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // phase error in
  input  wire logic                    err_valid,
  input  wire logic signed [ERR_W-1:0] err_word,
  // tuning word out
  output logic                         ftw_valid,
  output logic [ACC_W-1:0]             ftw_word
);
  logic signed [ERR_W+7:0] integ_r, integ_nxt;
  logic [ACC_W-1:0]        ftw_r, ftw_nxt;
  logic                    fv_r, fv_nxt;
  logic signed [ERR_W+7:0] prop;

  always_comb begin
    prop      = (ERR_W+8)'(err_word) <<< LF_KP_SHIFT;
    integ_nxt = integ_r;
    ftw_nxt   = ftw_r;
    fv_nxt    = 1'b0;
    if (err_valid) begin
      integ_nxt = integ_r + (ERR_W+8)'(err_word);
      // words go straight to the dds tuning input
      ftw_nxt   = NOM_FTW + ACC_W'(prop + (integ_nxt >>> LF_KI_SHIFT));
      fv_nxt    = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      integ_r <= '0;
      ftw_r   <= NOM_FTW;
      fv_r    <= 1'b0;
    end else begin
      integ_r <= integ_nxt;
      ftw_r   <= ftw_nxt;
      fv_r    <= fv_nxt;
    end
  end

  assign ftw_word  = ftw_r;
  assign ftw_valid = fv_r;

  property p_ftw_follows_err;
    @(posedge clk) disable iff (!reset_n)
      !err_valid |=> !ftw_valid && $stable(ftw_word);
  endproperty
  a_ftw_follows_err: assert property (p_ftw_follows_err)
    else $error("tuning word moved without an error word");
endmodule // dps_loop_filter

// file: logic/dps_core.sv
// dps_core: dpll core with phase build-out and slew-limited switchover.
// assumes ref_clk_in is asynchronous; profile inputs are held stable.
//
// How it works
// - build-out switchover hides old/new phase step
// - master when selection priority below threshold
// - threshold resets to zero, no masters
// - on switch, build out only non-masters
// - enabled slew controller limits output phase rate
// - 16-bit ns/s limit bounds switchover phase rate
// - slew limit zero disables slew controller
// - prescaler divides reference by R plus one
// - converter samples prescaler, detector emits error words
// - filter words drive dds tuning input
// - feedback divides by S plus one plus fraction
// - fraction from 10-bit numerator and denominator
// - cancel deterministic fractional divider phase error
// - priorities 0..7, zero is highest
`timescale 1ns/1ps
module dps_core
  import dps_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // register port
  input  wire logic                 reg_we,
  input  wire logic [11:0]          reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rdata,
  // reference pin and selection
  input  wire logic                 ref_clk_in,
  input  wire logic                 ref_switch,
  input  wire logic [PRIO_W-1:0]    prof_sel_prio,
  // profile divider settings
  input  wire logic [REF_DIV_W-1:0] prof_ref_div,
  input  wire logic [FB_INT_W-1:0]  prof_fb_int,
  input  wire logic [FRAC_W-1:0]    prof_frac_num,
  input  wire logic [FRAC_W-1:0]    prof_frac_den,
  // outputs
  output logic                      dds_clk_out,
  output logic [ACC_W-1:0]          dds_ftw,
  output logic signed [ERR_W-1:0]   phase_err,
  output logic                      phase_err_valid,
  output logic                      is_phase_master,
  output logic                      slew_active
);
  // registers
  logic [15:0]             slew_r, slew_nxt;
  logic [7:0]              thr_r, thr_nxt;
  logic [7:0]              rd_r, rd_nxt;
  // pin sync and prescaler
  logic                    ref_s1_r, ref_s2_r, ref_s3_r;
  logic [REF_DIV_W-1:0]    pre_r, pre_nxt;
  logic                    tdc_ev;
  // timestamps, dds, feedback divider
  logic [ACC_W-1:0]        ts_r, ts_nxt, fb_ts_r, fb_ts_nxt;
  logic [ACC_W-1:0]        acc_r, acc_nxt;
  logic [ACC_W-1:0]        per_r, per_nxt, last_roll_r, last_roll_nxt;
  logic [FB_INT_W:0]       fb_cnt_r, fb_cnt_nxt;
  logic [FRAC_W:0]         frac_r, frac_nxt, frac_at_fb_r, frac_at_fb_nxt;
  logic                    extra_r, extra_nxt;
  logic                    roll, fb_ev;
  logic [ACC_W:0]          acc_sum;
  logic [FRAC_W:0]         frac_sum;
  // switchover state
  logic                    master_r, master_nxt, pend_r, pend_nxt;
  logic                    slew_on_r, slew_on_nxt;
  logic signed [ERR_W-1:0] off_r, off_nxt, err_r, err_nxt;
  logic                    ev_r, ev_nxt;
  logic signed [ERR_W-1:0] raw_err, step;
  logic [ACC_W-1:0]        ftw_w;

  function automatic logic signed [ERR_W-1:0] frac_corr(
    input logic [FRAC_W:0] acc, input logic [ACC_W-1:0] per,
    input logic [FRAC_W-1:0] den);
    logic [ACC_W+FRAC_W:0] prod;
    prod = (ACC_W+FRAC_W+1)'(acc) * (ACC_W+FRAC_W+1)'(per);
    if (den == '0) frac_corr = '0;
    else frac_corr = ERR_W'(prod / (ACC_W+FRAC_W+1)'(den));
  endfunction

  function automatic logic signed [ERR_W-1:0] mag(
    input logic signed [ERR_W-1:0] v);
    mag = (v < 0) ? -v : v;
  endfunction

  // register port
  always_comb begin
    slew_nxt = slew_r;
    thr_nxt  = thr_r;
    if (reg_we) begin
      case (reg_addr)
        ADDR_SLEW_LO: slew_nxt[7:0]  = reg_wdata;
        ADDR_SLEW_HI: slew_nxt[15:8] = reg_wdata;
        ADDR_THRESH:  thr_nxt        = reg_wdata;
        default:      ;
      endcase
    end
    case (reg_addr)
      ADDR_SLEW_LO: rd_nxt = slew_r[7:0];
      ADDR_SLEW_HI: rd_nxt = slew_r[15:8];
      ADDR_THRESH:  rd_nxt = thr_r;
      ADDR_STATUS:  rd_nxt = {5'h00, slew_on_r, pend_r, master_r};
      default:      rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slew_r <= SLEW_RESET;
      thr_r  <= THRESH_RESET;
      rd_r   <= 8'h00;
    end else begin
      slew_r <= slew_nxt;
      thr_r  <= thr_nxt;
      rd_r   <= rd_nxt;
    end
  end

  // reference prescaler: one event per R+1 reference edges
  assign tdc_ev = ref_s2_r && !ref_s3_r && (pre_r == prof_ref_div);
  always_comb begin
    pre_nxt = pre_r;
    if (ref_s2_r && !ref_s3_r)
      pre_nxt = (pre_r == prof_ref_div) ? '0 : pre_r + 1'b1;
  end

  // dds accumulator and fractional feedback divider
  assign acc_sum  = {1'b0, acc_r} + {1'b0, ftw_w};
  assign roll     = acc_sum[ACC_W];
  assign frac_sum = frac_r + {1'b0, prof_frac_num};
  // S+1 rollovers, one more when the fraction overflows
  assign fb_ev    = roll && (fb_cnt_r >= ((FB_INT_W+1)'(prof_fb_int)
                    + (FB_INT_W+1)'(extra_r)));
  always_comb begin
    ts_nxt         = ts_r + 1'b1;
    acc_nxt        = acc_sum[ACC_W-1:0];
    per_nxt        = per_r;
    last_roll_nxt  = last_roll_r;
    fb_cnt_nxt     = fb_cnt_r;
    frac_nxt       = frac_r;
    extra_nxt      = extra_r;
    fb_ts_nxt      = fb_ts_r;
    frac_at_fb_nxt = frac_at_fb_r;
    if (roll) begin
      per_nxt       = ts_r - last_roll_r;
      last_roll_nxt = ts_r;
      fb_cnt_nxt    = fb_cnt_r + 1'b1;
    end
    if (fb_ev) begin
      fb_cnt_nxt     = '0;
      fb_ts_nxt      = ts_r;
      frac_at_fb_nxt = frac_r;
      // modulus U/V from the profile fraction fields
      if (prof_frac_den != '0 && frac_sum >= {1'b0, prof_frac_den}) begin
        frac_nxt  = frac_sum - {1'b0, prof_frac_den};
        extra_nxt = 1'b1;
      end else begin
        frac_nxt  = (prof_frac_den == '0) ? '0 : frac_sum;
        extra_nxt = 1'b0;
      end
    end
  end

  // detector, build-out and slew limiting
  // residual fraction is a known lag of the feedback edge
  assign raw_err = ERR_W'(ts_r - fb_ts_r)
                   - frac_corr(frac_at_fb_r, per_r, prof_frac_den);
  // ns/s scaled down to a per-sample step, never below one count
  assign step    = (slew_r >> SLEW_SHIFT) == 16'h0000 ? ERR_W'(1)
                   : ERR_W'(slew_r >> SLEW_SHIFT);
  always_comb begin
    master_nxt  = master_r;
    pend_nxt    = pend_r;
    off_nxt     = off_r;
    slew_on_nxt = slew_on_r;
    err_nxt     = err_r;
    ev_nxt      = 1'b0;
    if (ref_switch) begin
      // lower number is higher priority, 0 highest
      master_nxt = ({5'h00, prof_sel_prio} < thr_r);
      pend_nxt   = !master_nxt;
      if (master_nxt) off_nxt = '0;
      slew_on_nxt = (slew_r != SLEW_RESET);
    end else if (tdc_ev) begin
      ev_nxt  = 1'b1;
      err_nxt = raw_err - off_r;
      if (pend_r) begin
        off_nxt  = raw_err;
        err_nxt  = '0;
        pend_nxt = 1'b0;
      end else if (slew_on_r) begin
        // clamp the correction so the output phase ramps
        if (mag(raw_err - off_r) <= step) slew_on_nxt = 1'b0;
        else if (raw_err - off_r > 0) err_nxt = step;
        else err_nxt = -step;
      end
    end
    if (slew_r == SLEW_RESET) slew_on_nxt = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_s1_r     <= 1'b0;
      ref_s2_r     <= 1'b0;
      ref_s3_r     <= 1'b0;
      pre_r        <= '0;
      ts_r         <= CNT_RESET;
      acc_r        <= CNT_RESET;
      per_r        <= CNT_RESET;
      last_roll_r  <= CNT_RESET;
      fb_ts_r      <= CNT_RESET;
      fb_cnt_r     <= '0;
      frac_r       <= '0;
      frac_at_fb_r <= '0;
      extra_r      <= 1'b0;
      master_r     <= 1'b0;
      pend_r       <= 1'b0;
      off_r        <= '0;
      slew_on_r    <= 1'b0;
      err_r        <= '0;
      ev_r         <= 1'b0;
    end else begin
      ref_s1_r     <= ref_clk_in;
      ref_s2_r     <= ref_s1_r;
      ref_s3_r     <= ref_s2_r;
      pre_r        <= pre_nxt;
      ts_r         <= ts_nxt;
      acc_r        <= acc_nxt;
      per_r        <= per_nxt;
      last_roll_r  <= last_roll_nxt;
      fb_ts_r      <= fb_ts_nxt;
      fb_cnt_r     <= fb_cnt_nxt;
      frac_r       <= frac_nxt;
      frac_at_fb_r <= frac_at_fb_nxt;
      extra_r      <= extra_nxt;
      master_r     <= master_nxt;
      pend_r       <= pend_nxt;
      off_r        <= off_nxt;
      slew_on_r    <= slew_on_nxt;
      err_r        <= err_nxt;
      ev_r         <= ev_nxt;
    end
  end

  dps_loop_filter u_filter (
    .clk       (clk),
    .reset_n   (reset_n),
    .err_valid (ev_r),
    .err_word  (err_r),
    .ftw_valid (),
    .ftw_word  (ftw_w)
  );

  assign dds_clk_out     = acc_r[ACC_W-1];
  assign dds_ftw         = ftw_w;
  assign phase_err       = err_r;
  assign phase_err_valid = ev_r;
  assign is_phase_master = master_r;
  assign slew_active     = slew_on_r;
  assign reg_rdata       = rd_r;

  property p_master_cmp;
    @(posedge clk) disable iff (!reset_n)
      ref_switch |=> is_phase_master == ($past(prof_sel_prio) < $past(thr_r));
  endproperty
  a_master_cmp: assert property (p_master_cmp)
    else $error("phase master decision wrong");

  property p_master_no_buildout;
    @(posedge clk) disable iff (!reset_n)
      ref_switch && ({5'h00, prof_sel_prio} < thr_r) |=> !pend_r && off_r == 0;
  endproperty
  a_master_no_buildout: assert property (p_master_no_buildout)
    else $error("phase master was built out");

  property p_buildout_hides;
    @(posedge clk) disable iff (!reset_n)
      pend_r && tdc_ev && !ref_switch |=> phase_err_valid && phase_err == 0
        && off_r == $past(raw_err) && !pend_r;
  endproperty
  a_buildout_hides: assert property (p_buildout_hides)
    else $error("build-out switch leaked a phase step");

  property p_offset_sub;
    @(posedge clk) disable iff (!reset_n)
      !pend_r && !slew_on_r && tdc_ev && !ref_switch
        |=> phase_err == $past(raw_err) - $past(off_r);
  endproperty
  a_offset_sub: assert property (p_offset_sub)
    else $error("stored offset not removed from error");

  property p_slew_bound;
    @(posedge clk) disable iff (!reset_n)
      slew_on_r && !pend_r && tdc_ev && !ref_switch
        |=> mag(phase_err) <= $past(step);
  endproperty
  a_slew_bound: assert property (p_slew_bound)
    else $error("phase error step above slew limit");

  property p_slew_zero_off;
    @(posedge clk) disable iff (!reset_n)
      slew_r == 16'h0000 |=> !slew_active;
  endproperty
  a_slew_zero_off: assert property (p_slew_zero_off)
    else $error("slew controller on with zero limit");

  property p_prescale;
    @(posedge clk) disable iff (!reset_n)
      tdc_ev |=> pre_r == 0 ##0 !tdc_ev;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler did not restart after event");

  property p_sample_pulse;
    @(posedge clk) disable iff (!reset_n)
      tdc_ev && !ref_switch |=> phase_err_valid ##1 !phase_err_valid;
  endproperty
  a_sample_pulse: assert property (p_sample_pulse)
    else $error("error word not delivered one cycle after sample");

  property p_fb_len;
    @(posedge clk) disable iff (!reset_n)
      fb_ev |=> fb_cnt_r == 0;
  endproperty
  a_fb_len: assert property (p_fb_len)
    else $error("feedback divider did not restart");

  c_switch_master:   cover property (@(posedge clk) ref_switch ##1 master_r);
  c_switch_buildout: cover property (@(posedge clk) pend_r ##[1:1000] !pend_r);
  c_slew_clamp:      cover property (@(posedge clk) slew_on_r && ev_r);
endmodule // dps_core

// file: tb/dps_ref_src.sv
// dps_ref_src: behavioural reference clock source feeding the ref pin.
// assumes the bench gates it with en; the pin idles low between bursts.
`timescale 1ns/1ps
module dps_ref_src #(
  parameter int HALF_NS = 730
) (
  // control
  input  wire logic        en,
  // pin and edge count
  output logic             ref_clk,
  output logic [15:0]      edges
);
  // en only looked at in the low phase, so bursts hold whole periods
  initial begin
    ref_clk = 1'b0;
    edges   = 16'h0000;
    forever begin
      if (en) begin
        #(HALF_NS) ref_clk = 1'b1;
        edges = edges + 16'h0001;
        #(HALF_NS) ref_clk = 1'b0;
      end else begin
        #(HALF_NS / 4);
      end
    end
  end
endmodule // dps_ref_src

// file: tb/dps_core_tb.sv
// dps_core_tb: register, switchover, build-out, slew and prescaler tests.
// assumes a 10 MHz clock and the reference model in dps_ref_src.
`timescale 1ns/1ps
module dps_core_tb
  import dps_pkg::*;
;
  logic                    clk, reset_n, reg_we, ref_switch, ref_en;
  logic [11:0]             reg_addr;
  logic [7:0]              reg_wdata, reg_rdata, rd;
  logic [PRIO_W-1:0]       prof_sel_prio;
  logic [REF_DIV_W-1:0]    prof_ref_div;
  logic [FB_INT_W-1:0]     prof_fb_int;
  logic [FRAC_W-1:0]       prof_frac_num, prof_frac_den;
  logic                    dds_clk_out, phase_err_valid, ref_clk;
  logic                    is_phase_master, slew_active, grab, m, dds_prev;
  logic [ACC_W-1:0]        dds_ftw, ftw_seen;
  logic signed [ERR_W-1:0] phase_err, err_seen;
  logic [15:0]             edges;
  int                      n_errors, n_compared, n_samp, n_rise;

  dps_ref_src #(.HALF_NS(730)) u_src (
    .en(ref_en), .ref_clk(ref_clk), .edges(edges));

  dps_core u_dut (
    .clk(clk), .reset_n(reset_n), .reg_we(reg_we), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_clk_in(ref_clk),
    .ref_switch(ref_switch), .prof_sel_prio(prof_sel_prio),
    .prof_ref_div(prof_ref_div), .prof_fb_int(prof_fb_int),
    .prof_frac_num(prof_frac_num), .prof_frac_den(prof_frac_den),
    .dds_clk_out(dds_clk_out), .dds_ftw(dds_ftw), .phase_err(phase_err),
    .phase_err_valid(phase_err_valid), .is_phase_master(is_phase_master),
    .slew_active(slew_active));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // sampled mid-cycle so registered outputs are settled
  always @(negedge clk) begin
    if (phase_err_valid === 1'b1) begin
      n_samp++;
      err_seen = phase_err;
      grab = 1'b1;
    end else if (grab) begin
      ftw_seen = dds_ftw;
      grab = 1'b0;
    end
  end

  // rising edges of the dds msb, one look per cycle
  always @(negedge clk) begin
    if (dds_clk_out === 1'b1 && dds_prev === 1'b0) n_rise++;
    dds_prev = dds_clk_out;
  end

  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    tick(2);
    d = reg_rdata;
  endtask

  task automatic sw(input logic [2:0] p);
    @(posedge clk);
    ref_switch <= 1'b1;
    prof_sel_prio <= p;
    @(posedge clk);
    ref_switch <= 1'b0;
    tick(1);
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
  endtask

  // run n whole reference periods, then let the sync chain drain
  task automatic burst(input int n);
    logic [15:0] s;
    int          k;
    s = edges;
    k = 0;
    @(posedge clk);
    ref_en <= 1'b1;
    while (16'(edges - s) < 16'(n) && k < 5000) begin
      @(posedge clk);
      k++;
    end
    ref_en <= 1'b0;
    if (k >= 5000) n_errors++;
    tick(10);
  endtask

  initial begin
    reset_n = 1'b0;
    reg_we = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    ref_switch = 1'b0;
    ref_en = 1'b0;
    prof_sel_prio = 3'h0;
    prof_ref_div = 30'h0000_0003;
    prof_fb_int = 20'h0_0007;
    prof_frac_num = 10'h001;
    prof_frac_den = 10'h003;
    grab = 1'b0;
    n_errors = 0;
    n_compared = 0;
    n_samp = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    tick(1);
    chk("ftw_reset", dds_ftw, NOM_FTW);
    chk("dds_reset", {31'h0, dds_clk_out}, 32'h0);
    rd_reg(ADDR_SLEW_LO, rd);
    chk("slew_lo_reset", {24'h0, rd}, 32'h0);
    rd_reg(ADDR_SLEW_HI, rd);
    chk("slew_hi_reset", {24'h0, rd}, 32'h0);
    rd_reg(ADDR_THRESH, rd);
    chk("thresh_reset", {24'h0, rd}, 32'h0);
    // R=3: twelve reference edges give three phase samples
    burst(12);
    chk("sample_count", 32'(n_samp), 32'h3);
    // build-out after a fresh reset, threshold 0 so no master
    prof_ref_div <= 30'h0000_0000;
    do_reset();
    sw(3'h5);
    chk("master_thr0", {31'h0, is_phase_master}, 32'h0);
    rd_reg(ADDR_STATUS, rd);
    chk("status_pend", {24'h0, rd}, 32'h2);
    n_samp = 0;
    burst(1);
    chk("bo_samples", 32'(n_samp), 32'h1);
    chk("bo_err", err_seen, 32'h0);
    chk("bo_ftw", ftw_seen, NOM_FTW);
    rd_reg(ADDR_STATUS, rd);
    chk("status_done", {24'h0, rd}, 32'h0);
    // ftw still nominal: 2^32 / NOM_FTW = 256 cycles per dds period
    n_rise = 0;
    tick(2048);
    chk("dds_rises", 32'(n_rise), 32'h8);
    // every priority against threshold 4
    wr(ADDR_THRESH, 8'h04);
    rd_reg(ADDR_THRESH, rd);
    chk("thresh_rw", {24'h0, rd}, 32'h4);
    for (int p = 0; p < 8; p++) begin
      sw(3'(p));
      m = (p < 4);
      chk("master", {31'h0, is_phase_master}, {31'h0, m});
      rd_reg(ADDR_STATUS, rd);
      chk("status_prio", {24'h0, rd}, {29'h0, 1'b0, ~m, m});
    end
    // slew limit written per byte, active on switch, off when zeroed
    wr(ADDR_SLEW_LO, 8'h40);
    wr(ADDR_SLEW_HI, 8'h12);
    rd_reg(ADDR_SLEW_LO, rd);
    chk("slew_lo", {24'h0, rd}, 32'h40);
    rd_reg(ADDR_SLEW_HI, rd);
    chk("slew_hi", {24'h0, rd}, 32'h12);
    // limit 0x0040 gives a step of one count, so the sample after the build-out sample clamps
    wr(ADDR_SLEW_HI, 8'h00);
    sw(3'h5);
    chk("slew_on", {31'h0, slew_active}, 32'h1);
    rd_reg(ADDR_STATUS, rd);
    chk("status_slew", {24'h0, rd}, 32'h6);
    n_samp = 0;
    burst(2);
    chk("slew_samples", 32'(n_samp), 32'h2);
    chk("slew_step", (err_seen < 0) ? -err_seen : err_seen, 32'h1);
    chk("slew_hold", {31'h0, slew_active}, 32'h1);
    // integrator holds only this word: ftw = nom + (e << 4) + (e >>> 8)
    chk("slew_ftw", ftw_seen,
        err_seen[31] ? NOM_FTW - 32'h11 : NOM_FTW + 32'h10);
    wr(ADDR_SLEW_LO, 8'h00);
    wr(ADDR_SLEW_HI, 8'h00);
    tick(2);
    chk("slew_off", {31'h0, slew_active}, 32'h0);
    sw(3'h6);
    chk("slew_dis", {31'h0, slew_active}, 32'h0);
    // unmapped place: write ignored, reads zero
    wr(12'h318, 8'hA5);
    rd_reg(12'h318, rd);
    chk("unmapped", {24'h0, rd}, 32'h0);
    rd_reg(ADDR_SLEW_LO, rd);
    chk("slew_kept", {24'h0, rd}, 32'h0);
    give_verdict();
  end

  // whole run is well under a millisecond
  initial begin
    #5_000_000;
    n_errors++;
    give_verdict();
  end
endmodule // dps_core_tb
